// file: cip_pin_config.sv
// Notes on behaviour
// - Identification upper sixteen bits always return a fixed product code.
// - Bits 15:12 and 11:8 return fixed extra-code revision nibbles.
// - Bits 7:4 and 3:0 return read-only major and minor revisions.
// - Bit 27 enables the system clock pin; cleared means high impedance.
// - Bits 26:22 each enable one SDRAM clock pin, individually writable.
// - Bits 21:18 each enable one PCI clock pin, individually writable.
// - PCI clock enables start from address line 18 caught at reset.
// - Bit 17 with DMA select 1 picks DMA, GPIO or chip enables.
// - Bit 16 with flow select 1 picks RTS, GPIO or special output.
// - Bits 15:14 pick serial flow pins versus GPIO or interrupt inputs.
// - Bits 13:12 pick serial receive/transmit pins versus GPIO.
// - Bits 11:9 pick timer functions on done and channel 3 pins.
// - Bit 8 with timer bit 2 picks DMA done, timer or GPIO.
// - Bits 7:4 route DMA channels to pins or serial requests.
// - Bits 3:0 select DMA pin functions for each channel.
// - Channel 3 pins: DMA when selected, otherwise timer or GPIO per bit.
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module cip_pin_config #(
	parameter logic [15:0] PRODUCT_CODE = 16'h5a01, // arbitrary value
	parameter logic [3:0] MAJOR_EXTRA = 4'h1, // arbitrary value
	parameter logic [3:0] MINOR_EXTRA = 4'h1, // arbitrary value
	parameter logic [3:0] MAJOR_REV = 4'h1, // arbitrary value
	parameter logic [3:0] MINOR_REV = 4'h2, // arbitrary value
	parameter int ADDR_W = 32
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic pci_strap_addr18,
	output logic sys_clk_out_enable,
	output logic [4:0] sdram_clk_out_enable,
	output logic [3:0] pci_clk_out_enable,
	output cip_pkg::cip_pin_sel_t pin_sel,
	input wire logic [3:0] ext_dma_request,
	input wire logic [1:0] serial_tx_dma_request,
	input wire logic [1:0] serial_rx_dma_request,
	input wire logic [3:0] dmac_ack,
	output logic [3:0] dmac_req,
	output logic [3:0] ext_dma_ack,
	output cip_pkg::cip_ser_ack_t serial_ack
);

	if (ADDR_W != 32) begin : g_bad_addr_w
		$error("ADDR_W must be 32");
	end

	////////////////////////////////////////////////////////////////////////
	logic [27:0] cfg_r;
	logic rst_seen_r;
	logic aw_hold_r;
	logic w_hold_r;
	logic [31:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic aw_hold_nxt;
	logic w_hold_nxt;
	logic bvalid_nxt;
	logic rvalid_nxt;
	logic wr_do;
	logic ar_take;
	logic [31:0] id_word;
	logic [31:0] bmask;
	cip_pkg::cip_pin_sel_t sel_nxt;
	logic [3:0] int_req;

	assign id_word = {PRODUCT_CODE, MAJOR_EXTRA, MINOR_EXTRA, MAJOR_REV, MINOR_REV};
	// Channels 3 to 0 take tx1, tx0, rx1, rx0 when routed inside
	assign int_req = {serial_tx_dma_request, serial_rx_dma_request};
	assign wr_do = aw_hold_r && w_hold_r && !s_axi_bvalid;
	assign ar_take = s_axi_arvalid && s_axi_arready;
	assign bmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};

	always_comb begin
		aw_hold_nxt = aw_hold_r;
		w_hold_nxt = w_hold_r;
		bvalid_nxt = s_axi_bvalid;
		rvalid_nxt = s_axi_rvalid;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_hold_nxt = 1'b1;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_hold_nxt = 1'b1;
		end
		if (wr_do) begin
			aw_hold_nxt = 1'b0;
			w_hold_nxt = 1'b0;
			bvalid_nxt = 1'b1;
		end else if (s_axi_bvalid && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
		if (ar_take) begin
			rvalid_nxt = 1'b1;
		end else if (s_axi_rvalid && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Write channel: address and data are caught in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= cip_pkg::RESP_OKAY;
			awaddr_r <= 32'h00000000;
			wdata_r <= 32'h00000000;
			wstrb_r <= 4'h0;
		end else begin
			aw_hold_r <= aw_hold_nxt;
			w_hold_r <= w_hold_nxt;
			s_axi_bvalid <= bvalid_nxt;
			s_axi_awready <= !aw_hold_nxt && !bvalid_nxt;
			s_axi_wready <= !w_hold_nxt && !bvalid_nxt;
			if (s_axi_awvalid && s_axi_awready) begin
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (wr_do) begin
				if (awaddr_r == cip_pkg::ID_ADDR || awaddr_r == cip_pkg::CFG_ADDR) begin
					s_axi_bresp <= cip_pkg::RESP_OKAY;
				end else begin
					s_axi_bresp <= cip_pkg::RESP_SLVERR;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin configuration storage
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_r <= cip_pkg::CFG_RST;
			rst_seen_r <= 1'b0;
		end else if (!rst_seen_r) begin
			cfg_r[cip_pkg::PCI_LO +: cip_pkg::PCI_W] <= {4{pci_strap_addr18}};
			rst_seen_r <= 1'b1;
		end else if (wr_do && awaddr_r == cip_pkg::CFG_ADDR) begin
			cfg_r <= (cfg_r & ~bmask[27:0]) | (wdata_r[27:0] & bmask[27:0]);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= cip_pkg::RESP_OKAY;
		end else begin
			s_axi_rvalid <= rvalid_nxt;
			s_axi_arready <= !rvalid_nxt;
			if (ar_take) begin
				s_axi_rresp <= cip_pkg::RESP_OKAY;
				if (s_axi_araddr == cip_pkg::ID_ADDR) begin
					s_axi_rdata <= id_word;
				end else if (s_axi_araddr == cip_pkg::CFG_ADDR) begin
					s_axi_rdata <= {4'h0, cfg_r} & cip_pkg::CFG_WMASK;
				end else begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= cip_pkg::RESP_SLVERR;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin function decode
	always_comb begin
		sel_nxt = '{default: cip_pkg::FN_GPIO};
		if (cfg_r[cip_pkg::DMA_SEL_LO + 3]) begin
			sel_nxt.ch3_req = cip_pkg::FN_DMA;
			sel_nxt.ch3_ack = cip_pkg::FN_DMA;
		end else begin
			if (cfg_r[cip_pkg::TMR_LO + 1]) begin
				sel_nxt.ch3_req = cip_pkg::FN_TIMER;
			end
			if (cfg_r[cip_pkg::TMR_LO]) begin
				sel_nxt.ch3_ack = cip_pkg::FN_TIMER;
			end
		end
		if (cfg_r[cip_pkg::DMA_SEL_LO + 2]) begin
			sel_nxt.ch2_pair = cip_pkg::FN_DMA;
		end
		if (cfg_r[cip_pkg::DMA_SEL_LO]) begin
			sel_nxt.ch0_pair = cip_pkg::FN_DMA;
		end
		if (cfg_r[cip_pkg::DMA_SEL_LO + 1]) begin
			sel_nxt.ch1_pair = cip_pkg::FN_DMA;
		end else if (cfg_r[cip_pkg::CS_B]) begin
			sel_nxt.ch1_pair = cip_pkg::FN_CHIP_EN;
		end
		if (cfg_r[cip_pkg::DONE_B]) begin
			sel_nxt.done_pin = cip_pkg::FN_DMA;
		end else if (cfg_r[cip_pkg::TMR_LO + 2]) begin
			sel_nxt.done_pin = cip_pkg::FN_TIMER;
		end
		if (cfg_r[cip_pkg::SER_LO + 1]) begin
			sel_nxt.ser1_pair = cip_pkg::FN_SERIAL;
		end
		if (cfg_r[cip_pkg::SER_LO]) begin
			sel_nxt.ser0_pair = cip_pkg::FN_SERIAL;
		end
		if (cfg_r[cip_pkg::FLOW_LO + 1]) begin
			sel_nxt.cts1_pin = cip_pkg::FN_SERIAL;
			sel_nxt.rts1_pin = cip_pkg::FN_SERIAL;
		end else if (cfg_r[cip_pkg::SPECIAL_B]) begin
			sel_nxt.rts1_pin = cip_pkg::FN_SPECIAL;
		end
		sel_nxt.flow0_pair = cfg_r[cip_pkg::FLOW_LO] ? cip_pkg::FN_SERIAL : cip_pkg::FN_IRQ;
	end

	////////////////////////////////////////////////////////////////////////
	// Registered pin controls
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sys_clk_out_enable <= 1'b0;
			sdram_clk_out_enable <= 5'h00;
			pci_clk_out_enable <= 4'h0;
			pin_sel <= '{default: cip_pkg::FN_GPIO};
		end else begin
			sys_clk_out_enable <= cfg_r[cip_pkg::SYS_EN_B];
			sdram_clk_out_enable <= cfg_r[cip_pkg::SDR_LO +: cip_pkg::SDR_W];
			pci_clk_out_enable <= cfg_r[cip_pkg::PCI_LO +: cip_pkg::PCI_W];
			pin_sel <= sel_nxt;
		end
	end

	// DMA request routing
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dmac_req <= 4'h0;
			ext_dma_ack <= 4'h0;
			serial_ack <= '0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (cfg_r[cip_pkg::DMA_INT_LO + i]) begin
					dmac_req[i] <= int_req[i];
					ext_dma_ack[i] <= 1'b0;
				end else begin
					dmac_req[i] <= ext_dma_request[i];
					ext_dma_ack[i] <= dmac_ack[i];
				end
			end
			serial_ack.tx_ack <= dmac_ack[3:2] & cfg_r[cip_pkg::DMA_INT_LO + 2 +: 2];
			serial_ack.rx_ack <= dmac_ack[1:0] & cfg_r[cip_pkg::DMA_INT_LO +: 2];
		end
	end

	////////////////////////////////////////////////////////////////////////
	chk_id_code: assert property (@(posedge aclk) disable iff (!aresetn)
		ar_take && s_axi_araddr == cip_pkg::ID_ADDR |=> s_axi_rdata[31:16] == PRODUCT_CODE)
		else $error("product code wrong");
	chk_extra_code: assert property (@(posedge aclk) disable iff (!aresetn)
		ar_take && s_axi_araddr == cip_pkg::ID_ADDR
		|=> s_axi_rdata[15:8] == {MAJOR_EXTRA, MINOR_EXTRA})
		else $error("extra code wrong");
	chk_rev_code: assert property (@(posedge aclk) disable iff (!aresetn)
		ar_take && s_axi_araddr == cip_pkg::ID_ADDR
		|=> s_axi_rdata[7:0] == {MAJOR_REV, MINOR_REV})
		else $error("revision wrong");
	chk_sys_clk_gate: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_do && awaddr_r == cip_pkg::CFG_ADDR && wstrb_r[3] && rst_seen_r
		|-> ##2 sys_clk_out_enable == $past(wdata_r[27], 2))
		else $error("system clock enable not applied");
	chk_sdram_gate: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_do && awaddr_r == cip_pkg::CFG_ADDR && wstrb_r[3:2] == 2'h3 && rst_seen_r
		|-> ##2 sdram_clk_out_enable == $past(wdata_r[26:22], 2))
		else $error("sdram clock enables not applied");
	chk_pci_strap: assert property (@(posedge aclk) disable iff (!aresetn)
		!rst_seen_r |-> ##2 pci_clk_out_enable == {4{$past(pci_strap_addr18, 2)}})
		else $error("pci strap not loaded");
	chk_ch1_pins: assert property (@(posedge aclk) disable iff (!aresetn)
		!cfg_r[1] && cfg_r[17] |=> pin_sel.ch1_pair == cip_pkg::FN_CHIP_EN)
		else $error("channel 1 chip enable not selected");
	chk_ch3_pins: assert property (@(posedge aclk) disable iff (!aresetn)
		cfg_r[3] |=> pin_sel.ch3_req == cip_pkg::FN_DMA && pin_sel.ch3_ack == cip_pkg::FN_DMA)
		else $error("channel 3 dma not selected");
	chk_dma_route: assert property (@(posedge aclk) disable iff (!aresetn)
		cfg_r[7] |=> dmac_req[3] == $past(serial_tx_dma_request[1]))
		else $error("channel 3 not routed to serial");
	chk_cfg_upper: assert property (@(posedge aclk) disable iff (!aresetn)
		ar_take && s_axi_araddr == cip_pkg::CFG_ADDR |=> s_axi_rdata[31:28] == 4'h0)
		else $error("undefined bits not zero");
endmodule : cip_pin_config

// file: cip_pkg.sv
package cip_pkg;
	// Register byte addresses
	localparam logic [31:0] ID_ADDR = 32'hfffee004;
	localparam logic [31:0] CFG_ADDR = 32'hfffee008;
	// Pin configuration reset value and writable bits
	localparam logic [27:0] CFG_RST = 28'h0000000;
	localparam logic [31:0] CFG_WMASK = 32'h0fffffff;
	// Pin configuration field positions
	localparam int SYS_EN_B = 27;
	localparam int SDR_LO = 22;
	localparam int SDR_W = 5;
	localparam int PCI_LO = 18;
	localparam int PCI_W = 4;
	localparam int CS_B = 17;
	localparam int SPECIAL_B = 16;
	localparam int FLOW_LO = 14;
	localparam int SER_LO = 12;
	localparam int TMR_LO = 9;
	localparam int DONE_B = 8;
	localparam int DMA_INT_LO = 4;
	localparam int DMA_SEL_LO = 0;
	// Identification field positions
	localparam int ID_CODE_LO = 16;
	localparam int ID_MJE_LO = 12;
	localparam int ID_MNE_LO = 8;
	localparam int ID_MJ_LO = 4;
	localparam int ID_MN_LO = 0;
	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		FN_GPIO = 3'h0,
		FN_DMA = 3'h1,
		FN_TIMER = 3'h2,
		FN_CHIP_EN = 3'h3,
		FN_SERIAL = 3'h4,
		FN_SPECIAL = 3'h5,
		FN_IRQ = 3'h6
	} cip_fn_t;

	// Function chosen for each shared pin or pin pair
	typedef struct packed {
		cip_fn_t ch3_req;
		cip_fn_t ch3_ack;
		cip_fn_t ch2_pair;
		cip_fn_t ch1_pair;
		cip_fn_t ch0_pair;
		cip_fn_t done_pin;
		cip_fn_t ser1_pair;
		cip_fn_t ser0_pair;
		cip_fn_t cts1_pin;
		cip_fn_t rts1_pin;
		cip_fn_t flow0_pair;
	} cip_pin_sel_t;

	// DMA acknowledge routing toward the serial ports
	typedef struct packed {
		logic [1:0] tx_ack;
		logic [1:0] rx_ack;
	} cip_ser_ack_t;
endpackage : cip_pkg

// file: test_chip_id_and_pin_config.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
	$display("ERROR %s expected %h seen %h", nm, e, g); end end
module test_chip_id_and_pin_config;
	// Identity values are arbitrary
	localparam logic [15:0] PROD_V = 16'hc0de;
	localparam logic [3:0] MJE_V = 4'h3;
	localparam logic [3:0] MNE_V = 4'h5;
	localparam logic [3:0] MJ_V = 4'h6;
	localparam logic [3:0] MN_V = 4'h9;
	localparam logic [31:0] ID_V = {PROD_V, MJE_V, MNE_V, MJ_V, MN_V};
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = '0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, pci_strap_addr18 = 1'b1;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, serial_tx_dma_request = '0, serial_rx_dma_request = '0;
	logic sys_clk_out_enable;
	logic [4:0] sdram_clk_out_enable;
	logic [3:0] pci_clk_out_enable, dmac_req, ext_dma_ack, ext_dma_request = '0, dmac_ack = '0;
	cip_pkg::cip_pin_sel_t pin_sel;
	cip_pkg::cip_ser_ack_t serial_ack;
	int errors = 0;
	int n_checks = 0;
	logic [31:0] shadow;

	cip_pin_config #(.PRODUCT_CODE(PROD_V), .MAJOR_EXTRA(MJE_V), .MINOR_EXTRA(MNE_V),
		.MAJOR_REV(MJ_V), .MINOR_REV(MN_V), .ADDR_W(32)) dut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.pci_strap_addr18(pci_strap_addr18), .sys_clk_out_enable(sys_clk_out_enable),
		.sdram_clk_out_enable(sdram_clk_out_enable), .pci_clk_out_enable(pci_clk_out_enable),
		.pin_sel(pin_sel), .ext_dma_request(ext_dma_request),
		.serial_tx_dma_request(serial_tx_dma_request),
		.serial_rx_dma_request(serial_rx_dma_request), .dmac_ack(dmac_ack),
		.dmac_req(dmac_req), .ext_dma_ack(ext_dma_ack), .serial_ack(serial_ack));

	initial begin
		forever #25 aclk = ~aclk;
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : end_of_test

	task automatic bus_write(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r);
		int n;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (n == 100) begin
			errors++;
			end_of_test();
		end
	endtask : bus_write

	task automatic bus_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (n == 100) begin
			errors++;
			end_of_test();
		end
	endtask : bus_read

	function automatic cip_pkg::cip_pin_sel_t exp_sel(input logic [31:0] c);
		cip_pkg::cip_pin_sel_t p;
		p.ch3_req = c[3] ? cip_pkg::FN_DMA : (c[10] ? cip_pkg::FN_TIMER : cip_pkg::FN_GPIO);
		p.ch3_ack = c[3] ? cip_pkg::FN_DMA : (c[9] ? cip_pkg::FN_TIMER : cip_pkg::FN_GPIO);
		p.ch2_pair = c[2] ? cip_pkg::FN_DMA : cip_pkg::FN_GPIO;
		p.ch1_pair = c[1] ? cip_pkg::FN_DMA : (c[17] ? cip_pkg::FN_CHIP_EN : cip_pkg::FN_GPIO);
		p.ch0_pair = c[0] ? cip_pkg::FN_DMA : cip_pkg::FN_GPIO;
		p.done_pin = c[8] ? cip_pkg::FN_DMA : (c[11] ? cip_pkg::FN_TIMER : cip_pkg::FN_GPIO);
		p.ser1_pair = c[13] ? cip_pkg::FN_SERIAL : cip_pkg::FN_GPIO;
		p.ser0_pair = c[12] ? cip_pkg::FN_SERIAL : cip_pkg::FN_GPIO;
		p.cts1_pin = c[15] ? cip_pkg::FN_SERIAL : cip_pkg::FN_GPIO;
		p.rts1_pin = c[15] ? cip_pkg::FN_SERIAL : (c[16] ? cip_pkg::FN_SPECIAL : cip_pkg::FN_GPIO);
		p.flow0_pair = c[14] ? cip_pkg::FN_SERIAL : cip_pkg::FN_IRQ;
		return p;
	endfunction : exp_sel

	// Pin outputs against the shadow configuration and present DMA inputs
	task automatic chk_outs();
		logic [3:0] m;
		m = shadow[7:4];
		repeat (2) @(posedge aclk);
		`CHK("sys_en", shadow[27], sys_clk_out_enable)
		`CHK("sdram_en", shadow[26:22], sdram_clk_out_enable)
		`CHK("pci_en", shadow[21:18], pci_clk_out_enable)
		`CHK("pin_sel", exp_sel(shadow), pin_sel)
		`CHK("dmac_req", {m[3] ? serial_tx_dma_request[1] : ext_dma_request[3],
			m[2] ? serial_tx_dma_request[0] : ext_dma_request[2],
			m[1] ? serial_rx_dma_request[1] : ext_dma_request[1],
			m[0] ? serial_rx_dma_request[0] : ext_dma_request[0]}, dmac_req)
		`CHK("ext_ack", ~m & dmac_ack, ext_dma_ack)
		`CHK("ser_ack", m & dmac_ack, serial_ack)
	endtask : chk_outs

	task automatic do_reset(input logic s);
		logic [31:0] d;
		logic [1:0] r;
		aresetn <= 1'b0;
		pci_strap_addr18 <= s;
		repeat (2) @(posedge aclk);
		`CHK("rst_sel", 33'h0, pin_sel)
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		shadow = {10'h0, {4{s}}, 18'h0};
		chk_outs();
		bus_read(cip_pkg::CFG_ADDR, d, r);
		`CHK("rst_cfg", shadow, d)
		$display("reset test done, strap %0d", s);
	endtask : do_reset

	////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] d, msk;
		logic [3:0] s;
		logic [1:0] r;
		int i;
		i = $urandom(32'h379d);
		do_reset(1'b1);
		// Identification fixed and write-protected
		bus_read(cip_pkg::ID_ADDR, d, r);
		`CHK("id", ID_V, d)
		`CHK("id_resp", cip_pkg::RESP_OKAY, r)
		bus_write(cip_pkg::ID_ADDR, 32'hffffffff, 4'hf, r);
		`CHK("id_wresp", cip_pkg::RESP_OKAY, r)
		bus_read(cip_pkg::ID_ADDR, d, r);
		`CHK("id_after", ID_V, d)
		// Unmapped place refused
		bus_write(32'hfffee00c, 32'hffffffff, 4'hf, r);
		`CHK("unm_wresp", cip_pkg::RESP_SLVERR, r)
		bus_read(32'hfffee00c, d, r);
		`CHK("unm_rresp", cip_pkg::RESP_SLVERR, r)
		`CHK("unm_data", 32'h0, d)
		$display("identification test done");
		// Random configurations, corners first
		for (i = 0; i < 40; i++) begin
			d = (i == 0) ? 32'hffffffff : (i == 1) ? 32'h0 : $urandom;
			if (i >= 2) begin
				d[22] = 1'b1;
				d[18] = 1'b1;
			end
			s = (i < 2 || i[0]) ? 4'hf : 4'($urandom);
			msk = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & 32'h0fffffff;
			ext_dma_request <= 4'($urandom);
			serial_tx_dma_request <= 2'($urandom);
			serial_rx_dma_request <= 2'($urandom);
			dmac_ack <= 4'($urandom);
			bus_write(cip_pkg::CFG_ADDR, d, s, r);
			shadow = (shadow & ~msk) | (d & msk);
			`CHK("cfg_wresp", cip_pkg::RESP_OKAY, r)
			chk_outs();
			bus_read(cip_pkg::CFG_ADDR, d, r);
			`CHK("cfg_read", shadow, d)
		end
		$display("configuration test done");
		do_reset(1'b0);
		end_of_test();
	end
endmodule : test_chip_id_and_pin_config
